//--- sbf_pkg.sv
// Constants, helpers and register map of the servo speed flag and brake timing block
`default_nettype none
package sbf_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_TIME_US = 1000;
   // Microseconds to picoseconds, then clock periods per millisecond
   localparam int CYC_PER_MS = (TICK_TIME_US * 1000 * 1000) / CLK_PERIOD_PS;
   // Hysteresis band in r/min
   localparam logic [16:0] HYST_RPM = 17'h0000a;
   // Setting ranges and values after reset
   localparam logic [15:0] ZS_MIN = 16'h000a;
   localparam logic [15:0] ZS_MAX = 16'h4e20;
   localparam logic [15:0] ZS_RST = 16'h0032;
   localparam logic [15:0] SM_MIN = 16'h000a;
   localparam logic [15:0] SM_MAX = 16'h4e20;
   localparam logic [15:0] SM_RST = 16'h0032;
   localparam logic [15:0] DLY_MIN = 16'h0000;
   localparam logic [15:0] DLY_MAX = 16'h2710;
   localparam logic [15:0] DLY_RST = 16'h0000;
   localparam logic [15:0] BS_MIN = 16'h001e;
   localparam logic [15:0] BS_MAX = 16'h0bb8;
   localparam logic [15:0] BS_RST = 16'h001e;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ZS_THR = 8'h04;
   localparam logic [7:0] OFS_SM_WIN = 8'h08;
   localparam logic [7:0] OFS_STALL_DLY = 8'h0c;
   localparam logic [7:0] OFS_RUN_DLY = 8'h10;
   localparam logic [7:0] OFS_BRK_SPD = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   // Control bit: speed or torque control mode active
   localparam int CTRL_ST_MODE = 0;
   // Interrupt event bit positions
   localparam int EV_ZERO = 0;
   localparam int EV_MATCH = 1;
   localparam int EV_BRAKE = 2;
   localparam int EV_DEENERG = 3;
   localparam int EV_W = 4;
   localparam logic [3:0] EV_RST = 4'h0;
   // Brake sequence states, Gray along off-on-stall-run; on to run flips both bits
   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_ON = 2'b01,
      ST_STALL = 2'b11,
      ST_RUN = 2'b10
   } sbf_state_t;

   // Clamp a written setting into its legal range
   function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] r;
      r = lo;
      if (v < {16'h0000, lo})
         r = lo;
      else if (v > {16'h0000, hi})
         r = hi;
      else
         r = v[15:0];
      return r;
   endfunction

   // Magnitude of a signed speed, one bit wider to hold -32768
   function automatic logic [16:0] mag17(input logic signed [16:0] v);
      logic [16:0] r;
      r = v[16] ? 17'(-v) : 17'(v);
      return r;
   endfunction
endpackage
`default_nettype wire

//--- sbf_flag_if.sv
// Interface between brake sequencer core and its hysteresis flag unit
`timescale 1ns/1ps
`default_nettype none
interface sbf_flag_if;
   logic [16:0] speed_mag; // Motor speed magnitude
   logic [16:0] diff_mag; // Command minus speed, magnitude
   logic [15:0] zs_thr; // Zero-speed threshold
   logic [15:0] sm_win; // Speed match window
   logic match_en; // Speed or torque control active
   logic zero_flag; // Registered zero-speed flag
   logic match_flag; // Registered speed match flag
   modport core (output speed_mag, diff_mag, zs_thr, sm_win, match_en,
                 input zero_flag, match_flag);
   modport unit (input speed_mag, diff_mag, zs_thr, sm_win, match_en,
                 output zero_flag, match_flag);
endinterface
`default_nettype wire

//--- sbf_speed_flags.sv
// Hysteresis comparators for the zero-speed and speed match flags
`timescale 1ns/1ps
`default_nettype none
module sbf_speed_flags
(
   input wire logic clk,
   input wire logic rst,
   sbf_flag_if.unit flg
);
   logic zero_q; // Zero-speed flag
   logic zero_d;
   logic match_q; // Speed match flag
   logic match_d;

   // Next flag values; a dead band of 10 r/min stops chattering near the edge
   always_comb
   begin
      zero_d = zero_q;
      match_d = match_q;
      // Magnitude input makes both directions alike
      if (flg.speed_mag < {1'b0, flg.zs_thr})
         zero_d = 1'b1;
      else if (flg.speed_mag >= {1'b0, flg.zs_thr} + sbf_pkg::HYST_RPM)
         zero_d = 1'b0;
      // Match only meaningful in speed or torque control
      if (!flg.match_en)
         match_d = 1'b0;
      else if (flg.diff_mag <= {1'b0, flg.sm_win})
         match_d = 1'b1;
      else if (flg.diff_mag > {1'b0, flg.sm_win} + sbf_pkg::HYST_RPM)
         match_d = 1'b0;
   end

   // Flag registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         zero_q <= 1'b0;
         match_q <= 1'b0;
      end
      else
      begin
         zero_q <= zero_d;
         match_q <= match_d;
      end
   end

   assign flg.zero_flag = zero_q;
   assign flg.match_flag = match_q;
endmodule
`default_nettype wire

//--- sbf_brake_ctrl.sv
// Top of the servo speed flag and brake timing block
`timescale 1ns/1ps
`default_nettype none
module sbf_brake_ctrl
#(
   parameter int CYC_PER_MS = sbf_pkg::CYC_PER_MS // Shorten in simulation
)
(
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic SERVO_ON_CMD,
   input wire logic signed [15:0] MOTOR_SPEED,
   input wire logic signed [15:0] SPEED_CMD_RAMPED,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic ZERO_SPEED_FLAG,
   output logic SPEED_MATCH_FLAG,
   output logic BRAKE_RELEASE_OUT,
   output logic MOTOR_ENERGISE,
   output logic IRQ
);
   // Servo-on pin synchroniser
   logic son_meta_q; // First stage, read only by the second
   logic son_q; // Synchronised servo-on level

   // Settings
   logic ctrl_st_q; // Speed or torque control mode
   logic [15:0] zs_thr_q; // Zero-speed threshold
   logic [15:0] sm_win_q; // Speed match window
   logic [15:0] stall_dly_q; // Stopped brake delay in ms
   logic [15:0] run_dly_q; // Running brake delay in ms
   logic [15:0] brk_spd_q; // Brake release speed
   logic [3:0] irq_stat_q; // Sticky events
   logic [3:0] irq_mask_q; // Event enables
   logic [31:0] rdata_q; // Read data, one cycle after strobe
   logic irq_q; // Interrupt line
   logic ctrl_st_d;
   logic [15:0] zs_thr_d;
   logic [15:0] sm_win_d;
   logic [15:0] stall_dly_d;
   logic [15:0] run_dly_d;
   logic [15:0] brk_spd_d;
   logic [3:0] irq_stat_d;
   logic [3:0] irq_mask_d;
   logic [31:0] rdata_d;
   logic irq_d;

   // Sequencer state
   sbf_pkg::sbf_state_t st_q; // Brake sequence state
   sbf_pkg::sbf_state_t st_d;
   logic [17:0] div_q; // Millisecond prescaler
   logic [17:0] div_d;
   logic [15:0] ms_q; // Elapsed milliseconds of current delay
   logic [15:0] ms_d;
   logic brake_q; // Brake release drive
   logic brake_d;
   logic energ_q; // Motor energise drive
   logic energ_d;
   logic zero_prev_q; // Previous flags for edge events
   logic match_prev_q;
   logic tick; // One-millisecond strobe
   logic [3:0] ev; // Events this cycle

   sbf_flag_if flg ();

   // Magnitudes feed the comparators; speeds come from same-clock logic
   always_comb
   begin
      flg.speed_mag = sbf_pkg::mag17(17'(MOTOR_SPEED));
      flg.diff_mag = sbf_pkg::mag17(17'(SPEED_CMD_RAMPED) - 17'(MOTOR_SPEED));
      flg.zs_thr = zs_thr_q;
      flg.sm_win = sm_win_q;
      flg.match_en = ctrl_st_q;
   end

   sbf_speed_flags u_flags
   (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .flg(flg)
   );

   // Servo-on crosses from the host pin
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         son_meta_q <= 1'b0;
         son_q <= 1'b0;
      end
      else
      begin
         son_meta_q <= SERVO_ON_CMD;
         son_q <= son_meta_q;
      end
   end

   assign tick = (div_q == 18'(CYC_PER_MS - 1));

   // Brake sequencer next state
   always_comb
   begin
      st_d = st_q;
      brake_d = brake_q;
      energ_d = energ_q;
      // Prescaler free runs inside a delay; a fresh servo-off restarts it
      div_d = tick ? 18'h00000 : div_q + 18'h00001;
      ms_d = tick ? ms_q + 16'h0001 : ms_q;
      case (st_q)
         sbf_pkg::ST_OFF:
         begin
            brake_d = 1'b0;
            energ_d = 1'b0;
            if (son_q)
            begin
               // Energise and release together
               st_d = sbf_pkg::ST_ON;
               brake_d = 1'b1;
               energ_d = 1'b1;
            end
         end
         sbf_pkg::ST_ON:
         begin
            brake_d = 1'b1;
            energ_d = 1'b1;
            div_d = 18'h00000;
            ms_d = 16'h0000;
            if (!son_q)
            begin
               if (flg.zero_flag)
               begin
                  // Stopped: hold brake now, keep torque until it bites
                  st_d = sbf_pkg::ST_STALL;
                  brake_d = 1'b0;
               end
               else
               begin
                  // Moving: drop torque now, brake later
                  st_d = sbf_pkg::ST_RUN;
                  energ_d = 1'b0;
               end
            end
         end
         sbf_pkg::ST_STALL:
         begin
            if (son_q)
            begin
               // Servo-on returning cancels the delay
               st_d = sbf_pkg::ST_ON;
               brake_d = 1'b1;
               energ_d = 1'b1;
            end
            else if (ms_q >= stall_dly_q)
            begin
               st_d = sbf_pkg::ST_OFF;
               energ_d = 1'b0;
            end
         end
         sbf_pkg::ST_RUN:
         begin
            if (son_q)
            begin
               st_d = sbf_pkg::ST_ON;
               brake_d = 1'b1;
               energ_d = 1'b1;
            end
            // Whichever ends first: timeout or slow enough to brake
            else if ((ms_q >= run_dly_q) || (flg.speed_mag < {1'b0, brk_spd_q}))
            begin
               st_d = sbf_pkg::ST_OFF;
               brake_d = 1'b0;
            end
         end
         default:
         begin
            st_d = sbf_pkg::ST_OFF;
            brake_d = 1'b0;
            energ_d = 1'b0;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         st_q <= sbf_pkg::ST_OFF;
         div_q <= 18'h00000;
         ms_q <= 16'h0000;
         brake_q <= 1'b0;
         energ_q <= 1'b0;
         zero_prev_q <= 1'b0;
         match_prev_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         div_q <= div_d;
         ms_q <= ms_d;
         brake_q <= brake_d;
         energ_q <= energ_d;
         zero_prev_q <= flg.zero_flag;
         match_prev_q <= flg.match_flag;
      end
   end

   // Events: flag rises, brake engaging, torque removed
   always_comb
   begin
      ev = 4'h0;
      ev[sbf_pkg::EV_ZERO] = flg.zero_flag & ~zero_prev_q;
      ev[sbf_pkg::EV_MATCH] = flg.match_flag & ~match_prev_q;
      ev[sbf_pkg::EV_BRAKE] = brake_q & ~brake_d;
      ev[sbf_pkg::EV_DEENERG] = energ_q & ~energ_d;
   end

   // Register file next values; writes are clamped into legal ranges
   always_comb
   begin
      ctrl_st_d = ctrl_st_q;
      zs_thr_d = zs_thr_q;
      sm_win_d = sm_win_q;
      stall_dly_d = stall_dly_q;
      run_dly_d = run_dly_q;
      brk_spd_d = brk_spd_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      rdata_d = 32'h00000000;
      if (WR)
      begin
         case (ADDR)
            sbf_pkg::OFS_CTRL: ctrl_st_d = WDATA[sbf_pkg::CTRL_ST_MODE];
            sbf_pkg::OFS_ZS_THR:
               zs_thr_d = sbf_pkg::clamp16(WDATA, sbf_pkg::ZS_MIN, sbf_pkg::ZS_MAX);
            sbf_pkg::OFS_SM_WIN:
               sm_win_d = sbf_pkg::clamp16(WDATA, sbf_pkg::SM_MIN, sbf_pkg::SM_MAX);
            sbf_pkg::OFS_STALL_DLY:
               stall_dly_d = sbf_pkg::clamp16(WDATA, sbf_pkg::DLY_MIN, sbf_pkg::DLY_MAX);
            sbf_pkg::OFS_RUN_DLY:
               run_dly_d = sbf_pkg::clamp16(WDATA, sbf_pkg::DLY_MIN, sbf_pkg::DLY_MAX);
            sbf_pkg::OFS_BRK_SPD:
               brk_spd_d = sbf_pkg::clamp16(WDATA, sbf_pkg::BS_MIN, sbf_pkg::BS_MAX);
            sbf_pkg::OFS_IRQ_STAT: irq_stat_d = irq_stat_q & ~WDATA[3:0];
            sbf_pkg::OFS_IRQ_MASK: irq_mask_d = WDATA[3:0];
            default: ;
         endcase
      end
      // Set after clear so a same-cycle event survives
      irq_stat_d = irq_stat_d | ev;
      irq_d = |(irq_stat_d & irq_mask_d);
      if (RD)
      begin
         case (ADDR)
            sbf_pkg::OFS_CTRL: rdata_d = {31'h00000000, ctrl_st_q};
            sbf_pkg::OFS_ZS_THR: rdata_d = {16'h0000, zs_thr_q};
            sbf_pkg::OFS_SM_WIN: rdata_d = {16'h0000, sm_win_q};
            sbf_pkg::OFS_STALL_DLY: rdata_d = {16'h0000, stall_dly_q};
            sbf_pkg::OFS_RUN_DLY: rdata_d = {16'h0000, run_dly_q};
            sbf_pkg::OFS_BRK_SPD: rdata_d = {16'h0000, brk_spd_q};
            sbf_pkg::OFS_STATUS:
               rdata_d = {25'h0000000, st_q, son_q, energ_q, brake_q,
                          flg.match_flag, flg.zero_flag};
            sbf_pkg::OFS_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
            sbf_pkg::OFS_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
            default: rdata_d = 32'h00000000; // Unmapped reads as zero
         endcase
      end
   end

   // Register file
   always_ff @(posedge CLK_SYS)
   begin
      if (SYS_RST)
      begin
         ctrl_st_q <= 1'b0;
         zs_thr_q <= sbf_pkg::ZS_RST;
         sm_win_q <= sbf_pkg::SM_RST;
         stall_dly_q <= sbf_pkg::DLY_RST;
         run_dly_q <= sbf_pkg::DLY_RST;
         brk_spd_q <= sbf_pkg::BS_RST;
         irq_stat_q <= sbf_pkg::EV_RST;
         irq_mask_q <= sbf_pkg::EV_RST;
         rdata_q <= 32'h00000000;
         irq_q <= 1'b0;
      end
      else
      begin
         ctrl_st_q <= ctrl_st_d;
         zs_thr_q <= zs_thr_d;
         sm_win_q <= sm_win_d;
         stall_dly_q <= stall_dly_d;
         run_dly_q <= run_dly_d;
         brk_spd_q <= brk_spd_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   // All outputs straight from flops
   assign RDATA = rdata_q;
   assign ZERO_SPEED_FLAG = flg.zero_flag;
   assign SPEED_MATCH_FLAG = flg.match_flag;
   assign BRAKE_RELEASE_OUT = brake_q;
   assign MOTOR_ENERGISE = energ_q;
   assign IRQ = irq_q;
endmodule
`default_nettype wire

//--- sbf_brake_ctrl_properties.sv
// Pin-level checker for the speed flag and brake timing block
`timescale 1ns/1ps
`default_nettype none
module sbf_brake_ctrl_properties
#(
   parameter int CYC_PER_MS = 4 // Handed on from the design
)
(
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic SERVO_ON_CMD,
   input wire logic signed [15:0] MOTOR_SPEED,
   input wire logic signed [15:0] SPEED_CMD_RAMPED,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic ZERO_SPEED_FLAG,
   input wire logic SPEED_MATCH_FLAG,
   input wire logic BRAKE_RELEASE_OUT,
   input wire logic MOTOR_ENERGISE
);
   logic [16:0] spd; // Speed, sign extended
   logic [17:0] dif; // Command minus speed, wide enough not to wrap
   logic [16:0] spd_m; // Speed magnitude
   logic [17:0] dif_m; // Difference magnitude
   logic [15:0] zs_q, zs_d; // Shadow of zero-speed threshold
   logic [15:0] win_q, win_d; // Shadow of match window
   logic ctrl_q, ctrl_d; // Shadow of mode bit

   // Limit a written setting; both thresholds share 10..20000
   function automatic logic [15:0] lim(input logic [31:0] v);
      return (v < 32'h0000000a) ? 16'h000a : (v > 32'h00004e20) ? 16'h4e20 : v[15:0];
   endfunction

   assign spd = {MOTOR_SPEED[15], MOTOR_SPEED};
   assign dif = {{2{SPEED_CMD_RAMPED[15]}}, SPEED_CMD_RAMPED} - {spd[16], spd};
   assign spd_m = spd[16] ? -spd : spd;
   assign dif_m = dif[17] ? -dif : dif;

   // Settings are tracked from the bus, since only pins are visible
   always_comb
   begin
      zs_d = zs_q;
      win_d = win_q;
      ctrl_d = ctrl_q;
      if (WR && ADDR == sbf_pkg::OFS_ZS_THR)
         zs_d = lim(WDATA);
      if (WR && ADDR == sbf_pkg::OFS_SM_WIN)
         win_d = lim(WDATA);
      if (WR && ADDR == sbf_pkg::OFS_CTRL)
         ctrl_d = WDATA[0];
   end

   // Shadow registers
   always_ff @(posedge CLK_SYS)
   begin
      zs_q <= SYS_RST ? sbf_pkg::ZS_RST : zs_d;
      win_q <= SYS_RST ? sbf_pkg::SM_RST : win_d;
      ctrl_q <= SYS_RST ? 1'b0 : ctrl_d;
   end

   default clocking dc @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);

   // Both outputs high together
   sequence both_on;
      BRAKE_RELEASE_OUT && MOTOR_ENERGISE;
   endsequence

   zero_set_a: assert property ($rose(ZERO_SPEED_FLAG) |-> $past(spd_m) < $past(zs_q))
      else $error("zero flag rose at or above threshold");
   zero_clr_a: assert property ($fell(ZERO_SPEED_FLAG) |-> $past(spd_m) >= $past(zs_q) + 17'h0000a)
      else $error("zero flag fell inside hysteresis band");
   match_set_a: assert property ($rose(SPEED_MATCH_FLAG) |-> $past(ctrl_q) && $past(dif_m) <= $past(win_q))
      else $error("match flag rose outside window");
   match_clr_a: assert property ($fell(SPEED_MATCH_FLAG) |-> !$past(ctrl_q) || $past(dif_m) > $past(win_q) + 18'h0000a)
      else $error("match flag fell inside hysteresis band");
   match_off_a: assert property (!$past(ctrl_q) |-> !SPEED_MATCH_FLAG)
      else $error("match flag high outside speed or torque mode");
   son_release_a: assert property ($rose(SERVO_ON_CMD) |-> ##[2:4] both_on)
      else $error("servo-on did not release and energise");
   out_pair_a: assert property ($rose(BRAKE_RELEASE_OUT) || $rose(MOTOR_ENERGISE) |-> both_on)
      else $error("brake release and energise not together");
   stall_entry_a: assert property ($fell(BRAKE_RELEASE_OUT) && MOTOR_ENERGISE |-> $past(ZERO_SPEED_FLAG))
      else $error("brake first while motor was moving");
   run_entry_a: assert property ($fell(MOTOR_ENERGISE) && BRAKE_RELEASE_OUT |-> !$past(ZERO_SPEED_FLAG))
      else $error("de-energised first while motor was stopped");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h00000000)
      else $error("read data outside read answer cycle");
endmodule

bind sbf_brake_ctrl sbf_brake_ctrl_properties #(.CYC_PER_MS(CYC_PER_MS)) i_sbf_brake_ctrl_properties
(
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SERVO_ON_CMD(SERVO_ON_CMD),
   .MOTOR_SPEED(MOTOR_SPEED), .SPEED_CMD_RAMPED(SPEED_CMD_RAMPED), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ZERO_SPEED_FLAG(ZERO_SPEED_FLAG),
   .SPEED_MATCH_FLAG(SPEED_MATCH_FLAG), .BRAKE_RELEASE_OUT(BRAKE_RELEASE_OUT),
   .MOTOR_ENERGISE(MOTOR_ENERGISE)
);
`default_nettype wire

//--- sbf_brake_model.sv
// Mechanical brake seen from the drive: follows release line with a lag
`timescale 1ns/1ps
`default_nettype none
module sbf_brake_model
#(
   parameter int ACT_CYC = 3 // Mechanical action lag in clock cycles
)
(
   input wire logic clk,
   input wire logic brake_release,
   output logic engaged
);
   int lag = 0; // Cycles since command and shoe disagree
   logic eng_q = 1'b1; // Shoe state, engaged at power-up
   // Shoe moves only after its lag, so early de-energise shows up
   always @(posedge clk)
   begin
      lag <= (brake_release == eng_q) ? lag + 1 : 0;
      if (brake_release == eng_q && lag >= ACT_CYC - 1)
         eng_q <= !brake_release;
   end
   assign engaged = eng_q;
endmodule
`default_nettype wire

//--- sbf_brake_ctrl_tb.sv
// Self-checking bench for the speed flag and brake timing block
`timescale 1ns/1ps
`default_nettype none
module sbf_brake_ctrl_tb;
   localparam int CPM = 4; // Cycles per ms, shortened
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic son = 1'b0;
   logic signed [15:0] spd = 16'sh0000;
   logic signed [15:0] cmd = 16'sh0000;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, r;
   logic zsf, smf, brk, en, irq, engaged;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   int n;

   sbf_brake_ctrl #(.CYC_PER_MS(CPM)) i_sbf_brake_ctrl
   (
      .CLK_SYS(clk), .SYS_RST(rst), .SERVO_ON_CMD(son), .MOTOR_SPEED(spd),
      .SPEED_CMD_RAMPED(cmd), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .ZERO_SPEED_FLAG(zsf), .SPEED_MATCH_FLAG(smf), .BRAKE_RELEASE_OUT(brk),
      .MOTOR_ENERGISE(en), .IRQ(irq)
   );
   sbf_brake_model #(.ACT_CYC(3)) i_sbf_brake_model
   (
      .clk(clk), .brake_release(brk), .engaged(engaged)
   );

   initial
   begin
      forever #2 clk = ~clk;
   end

   // Hang guard, well above the run length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         miscompares = miscompares + 1;
         close_out();
      end
   end

   task automatic close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic drive(input logic signed [15:0] s, input logic signed [15:0] c);
      @(posedge clk);
      spd <= s;
      cmd <= c;
      tick(2);
   endtask

   task automatic servo(input logic v);
      @(posedge clk);
      son <= v;
      tick(6);
   endtask

   // Servo off, then wait until the named output drops
   task automatic off_wait_en;
      @(posedge clk);
      son <= 1'b0;
      for (n = 0; n < 20 && en === 1'b1; n++) tick(1);
   endtask

   task automatic t_regs;
      logic [7:0] a [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
      logic [31:0] e [6] = '{32'h00000032, 32'h00000032, 32'h00000000, 32'h00000000,
                             32'h0000001e, 32'h00000000};
      for (int i = 0; i < 6; i++)
      begin
         rd_reg(a[i], r);
         chk("reset value", e[i], r);
      end
      wr_reg(8'h04, 32'h00000005);
      rd_reg(8'h04, r);
      chk("zero thr low clamp", 32'h0000000a, r);
      wr_reg(8'h14, 32'h00000fa0);
      rd_reg(8'h14, r);
      chk("brake speed clamp", 32'h00000bb8, r);
      wr_reg(8'h0c, 32'h00002711);
      rd_reg(8'h0c, r);
      chk("stall delay clamp", 32'h00002710, r);
      rd_reg(8'hfc, r);
      chk("unmapped read", 32'h00000000, r);
      wr_reg(8'h04, 32'h00000032);
      wr_reg(8'h14, 32'h0000001e);
   endtask

   // Both directions, inside and outside the band, then a new threshold
   task automatic t_zero;
      logic signed [15:0] s [10] = '{16'sd49, -16'sd49, 16'sd55, 16'sd60, -16'sd55, -16'sd49,
                                     16'sd200, 16'sd99, 16'sd109, 16'sd110};
      logic x [10] = '{1, 1, 1, 0, 0, 1, 0, 1, 1, 0};
      for (int i = 0; i < 10; i++)
      begin
         if (i == 7)
            wr_reg(8'h04, 32'h00000064);
         drive(s[i], 16'sd0);
         chk("zero flag", x[i], zsf);
      end
      wr_reg(8'h04, 32'h00000032);
   endtask

   task automatic t_match;
      logic signed [15:0] s [6] = '{16'sd45, 16'sd39, 16'sd45, 16'sd50, 16'sd150, 16'sd161};
      logic x [6] = '{1, 0, 0, 1, 1, 0};
      drive(16'sd50, 16'sd100);
      chk("match off mode", 0, smf);
      wr_reg(8'h00, 32'h00000001);
      tick(2);
      chk("match at window", 1, smf);
      for (int i = 0; i < 6; i++)
      begin
         drive(s[i], 16'sd100);
         chk("match flag", x[i], smf);
      end
      // Flag high again so clearing the mode has something to drop
      drive(16'sd100, 16'sd100);
      chk("match before mode clear", 1, smf);
      wr_reg(8'h00, 32'h00000000);
      tick(2);
      chk("match mode cleared", 0, smf);
   endtask

   task automatic t_stall;
      wr_reg(8'h0c, 32'h00000002);
      drive(16'sd0, 16'sd0);
      servo(1'b1);
      chk("brake released", 1, brk);
      chk("energised", 1, en);
      @(posedge clk);
      son <= 1'b0;
      for (n = 0; n < 20 && brk === 1'b1; n++) tick(1);
      chk("energised at brake", 1, en);
      for (n = 0; n < 50 && en === 1'b1; n++) tick(1);
      chk("stall hold", 1, n >= 2 * CPM && n <= 2 * CPM + 2);
      chk("brake engaged", 1, engaged);
   endtask

   task automatic t_run;
      wr_reg(8'h10, 32'h00000003);
      wr_reg(8'h20, 32'h00000004);
      drive(16'sd500, 16'sd500);
      servo(1'b1);
      wr_reg(8'h1c, 32'h0000000f);
      off_wait_en();
      chk("brake at de-energise", 1, brk);
      for (n = 0; n < 50 && brk === 1'b1; n++) tick(1);
      chk("run hold", 1, n >= 3 * CPM && n <= 3 * CPM + 2);
      tick(2);
      chk("irq raised", 1, irq);
      rd_reg(8'h1c, r);
      chk("brake event", 1, r[2]);
      wr_reg(8'h20, 32'h00000000);
      tick(2);
      chk("irq masked", 0, irq);
      wr_reg(8'h20, 32'h00000004);
      wr_reg(8'h1c, 32'h00000004);
      tick(2);
      chk("irq cleared", 0, irq);
   endtask

   // Long delay, cut short once speed drops below the release speed
   task automatic t_speed;
      wr_reg(8'h10, 32'h00000064);
      drive(16'sd500, 16'sd500);
      servo(1'b1);
      off_wait_en();
      drive(16'sd40, 16'sd40);
      tick(8);
      chk("brake above speed", 1, brk);
      drive(16'sd20, 16'sd20);
      for (n = 0; n < 10 && brk === 1'b1; n++) tick(1);
      chk("speed exit", 1, n < 5);
   endtask

   task automatic t_cancel;
      drive(16'sd500, 16'sd500);
      servo(1'b1);
      off_wait_en();
      chk("de-energised", 0, en);
      servo(1'b1);
      chk("cancel brake", 1, brk);
      chk("cancel energise", 1, en);
      rd_reg(8'h18, r);
      chk("status after cancel", 32'h0000003c, r);
   endtask

   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_zero();
      t_match();
      t_stall();
      t_run();
      t_speed();
      t_cancel();
      close_out();
   end
endmodule
`default_nettype wire
